// [design/cycle_timing_pkg.sv]
// cycle_timing_pkg: types and constants for the instruction cycle-timing model.
// assumes: shared by the timing table and the model top; single clock domain.
package cycle_timing_pkg;

  // ----------------------------------------------------------------
  // counts and widths
  // ----------------------------------------------------------------
  localparam int          CLK_W            = 16;
  localparam int          CNT_W            = 8;
  localparam int          ACC_W            = 32;
  localparam logic [15:0] LOAD_PER_REG     = 16'h0004;
  localparam logic [15:0] STORE_PER_REG    = 16'h0003;
  localparam logic [31:0] ACC_RESET        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // selectors
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CASE_BEST  = 2'h0,
    CASE_CACHE = 2'h1,
    CASE_WORST = 2'h2
  } case_sel_t;

  // which address-time figure is added to the table entry
  typedef enum logic [2:0] {
    FN_NONE      = 3'h0,
    FN_FETCH_EA  = 3'h1,
    FN_CALC_EA   = 3'h2,
    FN_CALC_IMM  = 3'h3,
    FN_FETCH_IMM = 3'h4
  } foot_t;

  typedef enum logic [5:0] {
    I_EXG, I_CTRL_TO_REG, I_REG_TO_CTRL, I_PSW_TO_REG, I_PSW_TO_MEM, I_EA_TO_CCR,
    I_EA_TO_SR, I_MULTI_REG_LOAD, I_MULTI_REG_STORE, I_PERIPH_W_TO_MEM,
    I_PERIPH_L_TO_MEM, I_PERIPH_W_TO_REG, I_PERIPH_L_TO_REG, I_ALT_SPACE_LOAD,
    I_ALT_SPACE_STORE, I_MOVE_USP, I_SWAP,
    I_ADD_EA_DN, I_ADDA, I_ADD_DN_EA, I_AND_EA_DN, I_AND_DN_EA, I_EOR_DN_DN,
    I_EOR_DN_MEM, I_OR_EA_DN, I_OR_DN_EA, I_SUB_EA_DN, I_SUBA, I_SUB_DN_EA,
    I_CMP, I_CMPA, I_CMP2, I_MUL_W, I_MUL_L, I_DIVU_W, I_DIVU_L, I_DIVS_W, I_DIVS_L,
    I_QUICK_LOAD, I_ADDQ_RN, I_ADDQ_MEM, I_SUBQ_RN, I_SUBQ_MEM, I_ADDI_DN,
    I_ADDI_MEM, I_ANDI_DN, I_ANDI_MEM, I_EORI_DN, I_EORI_MEM, I_ORI_DN, I_ORI_MEM,
    I_SUBI_DN, I_SUBI_MEM, I_CMPI
  } instr_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CLK_W-1:0] clocks;
    logic [CNT_W-1:0] reads;
    logic [CNT_W-1:0] prefetches;
    logic [CNT_W-1:0] writes;
  } timing_t;

  // address-time figures for the requested case, from the sequencer
  typedef struct packed {
    timing_t fetch_ea;
    timing_t calc_ea;
    timing_t calc_imm;
    timing_t fetch_imm;
  } addr_time_t;

  typedef struct packed {
    logic [7:0] best;
    logic [7:0] cache;
    logic [7:0] worst;
    logic [3:0] reads;
    logic [3:0] writes;
    logic [1:0] worst_pf;
    foot_t      foot;
  } row_t;

endpackage

// [design/cycle_timing_table.sv]
// cycle_timing_table: per-instruction table entry lookup, purely combinational.
// assumes: instantiated by the model top; the instruction code is already registered
// or stable for the cycle.
`timescale 1ns/1ps
`default_nettype none
module cycle_timing_table (
  // lookup
  input  wire cycle_timing_pkg::instr_t i_instr,
  output var cycle_timing_pkg::row_t    o_row
);
  import cycle_timing_pkg::*;

  function automatic row_t mk(input logic [7:0] b, input logic [7:0] c, input logic [7:0] w,
                              input logic [3:0] r, input logic [3:0] wr,
                              input logic [1:0] p, input foot_t f);
    mk = '{best: b, cache: c, worst: w, reads: r, writes: wr, worst_pf: p, foot: f};
  endfunction

  // only the worst case shows a prefetch; best and cache prefetch nothing
  always_comb begin
    case (i_instr)
      I_EXG, I_MOVE_USP:
        o_row = mk(8'h00, 8'h02, 8'h03, 4'h0, 4'h0, 2'h1, FN_NONE);
      I_CTRL_TO_REG:     o_row = mk(8'h03, 8'h06, 8'h07, 4'h0, 4'h0, 2'h1, FN_NONE);
      I_REG_TO_CTRL:     o_row = mk(8'h09, 8'h0C, 8'h0D, 4'h0, 4'h0, 2'h1, FN_NONE);
      I_PSW_TO_REG:      o_row = mk(8'h01, 8'h04, 8'h05, 4'h0, 4'h0, 2'h1, FN_NONE);
      I_PSW_TO_MEM:      o_row = mk(8'h05, 8'h05, 8'h07, 4'h0, 4'h1, 2'h1, FN_CALC_EA);
      I_EA_TO_CCR:       o_row = mk(8'h04, 8'h04, 8'h05, 4'h0, 4'h0, 2'h1, FN_FETCH_EA);
      I_EA_TO_SR:        o_row = mk(8'h08, 8'h08, 8'h0B, 4'h0, 4'h0, 2'h2, FN_FETCH_EA);
      I_MULTI_REG_LOAD:  o_row = mk(8'h08, 8'h08, 8'h09, 4'h0, 4'h0, 2'h1, FN_CALC_IMM);
      I_MULTI_REG_STORE: o_row = mk(8'h04, 8'h04, 8'h05, 4'h0, 4'h0, 2'h1, FN_CALC_IMM);
      I_PERIPH_W_TO_MEM: o_row = mk(8'h08, 8'h0B, 8'h0B, 4'h0, 4'h2, 2'h1, FN_NONE);
      I_PERIPH_L_TO_MEM: o_row = mk(8'h0E, 8'h11, 8'h11, 4'h0, 4'h4, 2'h1, FN_NONE);
      I_PERIPH_W_TO_REG: o_row = mk(8'h0A, 8'h0C, 8'h0C, 4'h2, 4'h0, 2'h1, FN_NONE);
      I_PERIPH_L_TO_REG: o_row = mk(8'h10, 8'h12, 8'h12, 4'h4, 4'h0, 2'h1, FN_NONE);
      I_ALT_SPACE_LOAD:  o_row = mk(8'h07, 8'h07, 8'h08, 4'h1, 4'h0, 2'h1, FN_CALC_IMM);
      I_ALT_SPACE_STORE: o_row = mk(8'h05, 8'h05, 8'h07, 4'h0, 4'h1, 2'h1, FN_CALC_IMM);
      I_SWAP:            o_row = mk(8'h01, 8'h04, 8'h04, 4'h0, 4'h0, 2'h1, FN_NONE);
      // arithmetic and logical; worst case carries the next prefetch
      I_ADD_EA_DN, I_ADDA, I_AND_EA_DN, I_EOR_DN_DN, I_OR_EA_DN, I_SUB_EA_DN, I_SUBA,
      I_CMP:
        o_row = mk(8'h00, 8'h02, 8'h03, 4'h0, 4'h0, 2'h1, FN_FETCH_EA);
      I_ADD_DN_EA, I_AND_DN_EA, I_EOR_DN_MEM, I_OR_DN_EA, I_SUB_DN_EA:
        o_row = mk(8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 2'h1, FN_FETCH_EA);
      I_CMPA:   o_row = mk(8'h01, 8'h04, 8'h04, 4'h0, 4'h0, 2'h1, FN_FETCH_EA);
      I_CMP2:   o_row = mk(8'h10, 8'h12, 8'h12, 4'h1, 4'h0, 2'h1, FN_FETCH_IMM);
      I_MUL_W:  o_row = mk(8'h19, 8'h1B, 8'h1C, 4'h0, 4'h0, 2'h1, FN_FETCH_EA);
      I_MUL_L:  o_row = mk(8'h29, 8'h2B, 8'h2C, 4'h0, 4'h0, 2'h1, FN_FETCH_IMM);
      I_DIVU_W: o_row = mk(8'h2A, 8'h2C, 8'h2C, 4'h0, 4'h0, 2'h1, FN_FETCH_EA);
      I_DIVU_L: o_row = mk(8'h4C, 8'h4E, 8'h4F, 4'h0, 4'h0, 2'h1, FN_FETCH_IMM);
      I_DIVS_W: o_row = mk(8'h36, 8'h38, 8'h39, 4'h0, 4'h0, 2'h1, FN_FETCH_EA);
      I_DIVS_L: o_row = mk(8'h58, 8'h5A, 8'h5B, 4'h0, 4'h0, 2'h1, FN_FETCH_IMM);
      // immediate forms: ADDI/ANDI/EORI/ORI/SUBI/CMPI figures add fetching the immediate source; quick forms do not
      I_QUICK_LOAD, I_ADDQ_RN, I_SUBQ_RN:
        o_row = mk(8'h00, 8'h02, 8'h03, 4'h0, 4'h0, 2'h1, FN_NONE);
      I_ADDQ_MEM, I_SUBQ_MEM:
        o_row = mk(8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 2'h1, FN_FETCH_EA);
      I_ADDI_DN, I_ANDI_DN, I_EORI_DN, I_ORI_DN, I_SUBI_DN, I_CMPI:
        o_row = mk(8'h00, 8'h02, 8'h03, 4'h0, 4'h0, 2'h1, FN_FETCH_IMM);
      I_ADDI_MEM, I_ANDI_MEM, I_EORI_MEM, I_ORI_MEM, I_SUBI_MEM:
        o_row = mk(8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 2'h1, FN_FETCH_IMM);
      default:  o_row = mk(8'h00, 8'h00, 8'h00, 4'h0, 4'h0, 2'h0, FN_NONE);
    endcase
  end

endmodule // cycle_timing_table
`default_nettype wire

// [design/instruction_cycle_timing_model.sv]
// instruction_cycle_timing_model: answers each sequencer query with a clock total and
// its read / prefetch / write breakdown, and keeps running totals.
// assumes: sequencer logic on i_clk supplies the address-time figures for the case asked.
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_model #(
  parameter int NREG_W = 5
) (
  // clock and reset
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  // query from the sequencer
  input  wire logic                            i_req,
  input  wire cycle_timing_pkg::instr_t        i_instr,
  input  wire cycle_timing_pkg::case_sel_t     i_case,
  input  wire logic [NREG_W-1:0]               i_nregs,
  input  wire cycle_timing_pkg::addr_time_t    i_addr_time,
  // answer
  output logic                                 o_valid,
  output var cycle_timing_pkg::timing_t        o_timing,
  // running totals
  output logic [cycle_timing_pkg::ACC_W-1:0]   o_acc_clocks,
  output logic [cycle_timing_pkg::ACC_W-1:0]   o_acc_instrs
);
  import cycle_timing_pkg::*;

  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  row_t row;

  cycle_timing_table u_table (
    .i_instr (i_instr),
    .o_row   (row)
  );

  function automatic timing_t add_timing(input timing_t a, input timing_t b);
    add_timing.clocks     = CLK_W'(a.clocks + b.clocks);
    add_timing.reads      = CNT_W'(a.reads + b.reads);
    add_timing.prefetches = CNT_W'(a.prefetches + b.prefetches);
    add_timing.writes     = CNT_W'(a.writes + b.writes);
  endfunction

  // ----------------------------------------------------------------
  // figure for this query
  // ----------------------------------------------------------------
  timing_t base;
  timing_t extra;
  timing_t total;

  always_comb begin
    base = '0;
    case (i_case)
      CASE_BEST:  base.clocks = CLK_W'(row.best);
      CASE_CACHE: base.clocks = CLK_W'(row.cache);
      default: begin
        base.clocks     = CLK_W'(row.worst);
        base.prefetches = CNT_W'(row.worst_pf);
      end
    endcase
    // bus counts sit inside the clock figure; they only ride along
    base.reads  = CNT_W'(row.reads);
    base.writes = CNT_W'(row.writes);
    if (i_instr == I_MULTI_REG_LOAD) begin
      base.clocks = CLK_W'(base.clocks + CLK_W'(i_nregs) * LOAD_PER_REG);
      base.reads  = CNT_W'(base.reads + CNT_W'(i_nregs));
    end else if (i_instr == I_MULTI_REG_STORE) begin
      base.clocks = CLK_W'(base.clocks + CLK_W'(i_nregs) * STORE_PER_REG);
      base.writes = CNT_W'(base.writes + CNT_W'(i_nregs));
    end
    case (row.foot)
      FN_FETCH_EA:  extra = i_addr_time.fetch_ea;
      FN_CALC_EA:   extra = i_addr_time.calc_ea;
      FN_CALC_IMM:  extra = i_addr_time.calc_imm;
      FN_FETCH_IMM: extra = i_addr_time.fetch_imm;
      default:      extra = '0;
    endcase
    total = add_timing(base, extra);
  end

  // ----------------------------------------------------------------
  // answer and totals
  // ----------------------------------------------------------------
  logic                  valid_q, valid_d;
  timing_t               timing_q, timing_d;
  logic [ACC_W-1:0]      acc_clk_q, acc_clk_d;
  logic [ACC_W-1:0]      acc_ins_q, acc_ins_d;

  always_comb begin
    valid_d   = i_req;
    timing_d  = i_req ? total : timing_q;
    acc_clk_d = i_req ? ACC_W'(acc_clk_q + ACC_W'(total.clocks)) : acc_clk_q;
    acc_ins_d = i_req ? ACC_W'(acc_ins_q + 32'h0000_0001) : acc_ins_q;
  end

  // reset clears the totals, the answer strobe and the held answer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      valid_q   <= 1'b0;
      timing_q  <= '0;
      acc_clk_q <= ACC_RESET;
      acc_ins_q <= ACC_RESET;
    end else begin
      valid_q   <= valid_d;
      timing_q  <= timing_d;
      acc_clk_q <= acc_clk_d;
      acc_ins_q <= acc_ins_d;
    end
  end

  assign o_valid      = valid_q;
  assign o_timing     = timing_q;
  assign o_acc_clocks = acc_clk_q;
  assign o_acc_instrs = acc_ins_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // query copies so checks can relate the answer to what was asked
  instr_t            h_instr_q;
  case_sel_t         h_case_q;
  logic [NREG_W-1:0] h_n_q;
  addr_time_t        h_addr_q;

  always_ff @(posedge i_clk) begin
    h_instr_q <= i_instr;
    h_case_q  <= i_case;
    h_n_q     <= i_nregs;
    h_addr_q  <= i_addr_time;
  end

  property p_answer_next;
    @(posedge i_clk) disable iff (i_rst)
    i_req |=> o_valid ##1 (o_valid == $past(i_req));
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("answer not one clock after the query");

  property p_no_idle_answer;
    @(posedge i_clk) disable iff (i_rst)
    (!i_req [*2]) |=> !o_valid && $stable(o_timing);
  endproperty
  a_no_idle_answer: assert property (p_no_idle_answer)
    else $error("answer without a query or changed while idle");

  property p_load_figure;
    @(posedge i_clk) disable iff (i_rst)
    o_valid && $past(i_req) && h_instr_q == I_MULTI_REG_LOAD |->
      o_timing.clocks == CLK_W'((h_case_q == CASE_WORST ? 9 : 8) + 4 * h_n_q
                                + h_addr_q.calc_imm.clocks)
      && o_timing.reads == CNT_W'(h_n_q + h_addr_q.calc_imm.reads);
  endproperty
  a_load_figure: assert property (p_load_figure)
    else $error("multi-register load figure wrong");

  property p_store_figure;
    @(posedge i_clk) disable iff (i_rst)
    o_valid && $past(i_req) && h_instr_q == I_MULTI_REG_STORE |->
      o_timing.clocks == CLK_W'((h_case_q == CASE_WORST ? 5 : 4) + 3 * h_n_q
                                + h_addr_q.calc_imm.clocks)
      && o_timing.writes == CNT_W'(h_n_q + h_addr_q.calc_imm.writes)
      && o_timing.prefetches == CNT_W'((h_case_q == CASE_WORST ? 1 : 0)
                                       + h_addr_q.calc_imm.prefetches);
  endproperty
  a_store_figure: assert property (p_store_figure)
    else $error("multi-register store figure wrong");

  property p_worst_prefetch;
    @(posedge i_clk) disable iff (i_rst)
    i_req && i_instr == I_ADD_DN_EA |=>
      o_timing.prefetches == CNT_W'((h_case_q == CASE_WORST ? 1 : 0)
                                    + h_addr_q.fetch_ea.prefetches);
  endproperty
  a_worst_prefetch: assert property (p_worst_prefetch)
    else $error("worst-case prefetch not added");

  property p_fetch_class;
    @(posedge i_clk) disable iff (i_rst)
    i_req && i_case == CASE_CACHE && (i_instr == I_DIVS_L || i_instr == I_DIVS_W) |=>
      o_timing.clocks == (h_instr_q == I_DIVS_L ?
        CLK_W'(90 + h_addr_q.fetch_imm.clocks) : CLK_W'(56 + h_addr_q.fetch_ea.clocks));
  endproperty
  a_fetch_class: assert property (p_fetch_class)
    else $error("wrong address time added for the class");

  property p_alt_space;
    @(posedge i_clk) disable iff (i_rst)
    i_req && i_case == CASE_BEST && i_instr == I_ALT_SPACE_STORE |=>
      o_timing.clocks == CLK_W'(5 + h_addr_q.calc_imm.clocks)
      && o_timing.writes == CNT_W'(1 + h_addr_q.calc_imm.writes);
  endproperty
  a_alt_space: assert property (p_alt_space)
    else $error("alternate-space move figure wrong");

  property p_immediate;
    @(posedge i_clk) disable iff (i_rst)
    i_req && i_case == CASE_WORST && i_instr == I_ADDI_MEM |=>
      o_timing.clocks == CLK_W'(6 + h_addr_q.fetch_imm.clocks);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate operation figure wrong");

  property p_included;
    @(posedge i_clk) disable iff (i_rst)
    i_req && i_case == CASE_BEST && i_instr == I_PERIPH_L_TO_MEM |=>
      o_timing.clocks == 16'h000E && o_timing.writes == 8'h04 && o_timing.reads == 8'h00;
  endproperty
  a_included: assert property (p_included)
    else $error("bus cycles added to the clock total");

  property p_total_tracks;
    @(posedge i_clk) disable iff (i_rst)
    o_valid && $past(i_req) |->
      o_acc_clocks == ACC_W'($past(o_acc_clocks) + o_timing.clocks);
  endproperty
  a_total_tracks: assert property (p_total_tracks)
    else $error("running clock total out of step");

endmodule // instruction_cycle_timing_model
`default_nettype wire

// [verif/tb_instruction_cycle_timing_model.sv]
// tb_instruction_cycle_timing_model: self-checking bench for the cycle-timing model.
// assumes: the bench acts as sequencer; fixed address-time figures, one per footnote kind.
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_cycle_timing_model;
  import cycle_timing_pkg::*;
  localparam int NW = 5;
  // clock and reset
  logic                 i_clk;
  logic                 i_rst;
  // query
  logic                 i_req;
  instr_t               i_instr;
  case_sel_t            i_case;
  logic [NW-1:0]        i_nregs;
  addr_time_t           at;
  // answer
  logic                 o_valid;
  timing_t              o_timing;
  logic [ACC_W-1:0]     o_acc_clocks;
  logic [ACC_W-1:0]     o_acc_instrs;
  int                   err_total;
  int                   cmp_count;
  logic [ACC_W-1:0]     exp_clk;
  logic [ACC_W-1:0]     exp_n;

  instruction_cycle_timing_model #(.NREG_W(NW)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_instr(i_instr), .i_case(i_case),
    .i_nregs(i_nregs), .i_addr_time(at), .o_valid(o_valid), .o_timing(o_timing),
    .o_acc_clocks(o_acc_clocks), .o_acc_instrs(o_acc_instrs)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic timing_t mk(int c, int r, int p, int w);
    return {c[15:0], r[7:0], p[7:0], w[7:0]};
  endfunction

  function automatic timing_t add(timing_t a, timing_t b);
    add.clocks     = a.clocks + b.clocks;
    add.reads      = a.reads + b.reads;
    add.prefetches = a.prefetches + b.prefetches;
    add.writes     = a.writes + b.writes;
  endfunction

  // 0 none, 1 fetch ea, 2 calc ea, 3 calc imm, 4 fetch imm
  function automatic timing_t pick(int f);
    case (f)
      1: return at.fetch_ea;
      2: return at.calc_ea;
      3: return at.calc_imm;
      4: return at.fetch_imm;
      default: return '0;
    endcase
  endfunction

  task automatic chk_t(timing_t got, timing_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk32(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one query, answer judged in the following cycle
  task automatic q(instr_t ins, case_sel_t cs, int n, timing_t exp);
    @(negedge i_clk);
    i_req   = 1'b1;
    i_instr = ins;
    i_case  = cs;
    i_nregs = n[NW-1:0];
    @(negedge i_clk);
    i_req   = 1'b0;
    exp_clk = exp_clk + {16'h0000, exp.clocks};
    exp_n   = exp_n + 32'h0000_0001;
    chk32({31'h0, o_valid}, 32'h0000_0001);
    chk_t(o_timing, exp);
    chk32(o_acc_clocks, exp_clk);
    chk32(o_acc_instrs, exp_n);
  endtask

  task automatic run_row(instr_t ins, int b, int c, int w, int r, int wr, int pw, int f);
    q(ins, CASE_BEST, 0, add(mk(b, r, 0, wr), pick(f)));
    q(ins, CASE_CACHE, 0, add(mk(c, r, 0, wr), pick(f)));
    q(ins, CASE_WORST, 0, add(mk(w, r, pw, wr), pick(f)));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_multi;
    int ns [3] = '{0, 1, 31};
    foreach (ns[k]) begin
      q(I_MULTI_REG_LOAD, CASE_BEST, ns[k], add(mk(8 + 4*ns[k], ns[k], 0, 0), at.calc_imm));
      q(I_MULTI_REG_LOAD, CASE_CACHE, ns[k], add(mk(8 + 4*ns[k], ns[k], 0, 0), at.calc_imm));
      q(I_MULTI_REG_LOAD, CASE_WORST, ns[k], add(mk(9 + 4*ns[k], ns[k], 1, 0), at.calc_imm));
      q(I_MULTI_REG_STORE, CASE_BEST, ns[k], add(mk(4 + 3*ns[k], 0, 0, ns[k]), at.calc_imm));
      q(I_MULTI_REG_STORE, CASE_CACHE, ns[k], add(mk(4 + 3*ns[k], 0, 0, ns[k]), at.calc_imm));
      q(I_MULTI_REG_STORE, CASE_WORST, ns[k], add(mk(5 + 3*ns[k], 0, 1, ns[k]), at.calc_imm));
    end
    $display("test multi_register_move done");
  endtask

  task automatic t_special;
    run_row(I_ALT_SPACE_LOAD, 7, 7, 8, 1, 0, 1, 3);
    run_row(I_ALT_SPACE_STORE, 5, 5, 7, 0, 1, 1, 3);
    run_row(I_EA_TO_SR, 8, 8, 11, 0, 0, 2, 1);
    run_row(I_PSW_TO_MEM, 5, 5, 7, 0, 1, 1, 2);
    run_row(I_PERIPH_L_TO_MEM, 14, 17, 17, 0, 4, 1, 0);
    run_row(I_EXG, 0, 2, 3, 0, 0, 1, 0);
    run_row(I_CTRL_TO_REG, 3, 6, 7, 0, 0, 1, 0);
    run_row(I_REG_TO_CTRL, 9, 12, 13, 0, 0, 1, 0);
    run_row(I_PSW_TO_REG, 1, 4, 5, 0, 0, 1, 0);
    run_row(I_EA_TO_CCR, 4, 4, 5, 0, 0, 1, 1);
    run_row(I_PERIPH_W_TO_MEM, 8, 11, 11, 0, 2, 1, 0);
    run_row(I_PERIPH_W_TO_REG, 10, 12, 12, 2, 0, 1, 0);
    run_row(I_PERIPH_L_TO_REG, 16, 18, 18, 4, 0, 1, 0);
    run_row(I_MOVE_USP, 0, 2, 3, 0, 0, 1, 0);
    run_row(I_SWAP, 1, 4, 4, 0, 0, 1, 0);
    $display("test special alternate_space_move done");
  endtask

  task automatic t_arith;
    run_row(I_ADD_EA_DN, 0, 2, 3, 0, 0, 1, 1);
    run_row(I_ADD_DN_EA, 3, 4, 6, 0, 1, 1, 1);
    run_row(I_CMP2, 16, 18, 18, 1, 0, 1, 4);
    run_row(I_DIVU_L, 76, 78, 79, 0, 0, 1, 4);
    run_row(I_MUL_W, 25, 27, 28, 0, 0, 1, 1);
    run_row(I_MUL_L, 41, 43, 44, 0, 0, 1, 4);
    run_row(I_DIVU_W, 42, 44, 44, 0, 0, 1, 1);
    run_row(I_DIVS_W, 54, 56, 57, 0, 0, 1, 1);
    run_row(I_DIVS_L, 88, 90, 91, 0, 0, 1, 4);
    run_row(I_CMPA, 1, 4, 4, 0, 0, 1, 1);
    run_row(I_EOR_DN_DN, 0, 2, 3, 0, 0, 1, 1);
    run_row(I_SUB_DN_EA, 3, 4, 6, 0, 1, 1, 1);
    q(I_ADD_EA_DN, case_sel_t'(2'h3), 0, add(mk(3, 0, 1, 0), at.fetch_ea));
    $display("test arithmetic done");
  endtask

  task automatic t_imm;
    run_row(I_ADDI_MEM, 3, 4, 6, 0, 1, 1, 4);
    run_row(I_ADDQ_MEM, 3, 4, 6, 0, 1, 1, 1);
    run_row(I_QUICK_LOAD, 0, 2, 3, 0, 0, 1, 0);
    run_row(I_CMPI, 0, 2, 3, 0, 0, 1, 4);
    run_row(I_ADDQ_RN, 0, 2, 3, 0, 0, 1, 0);
    run_row(I_SUBI_MEM, 3, 4, 6, 0, 1, 1, 4);
    run_row(I_ORI_DN, 0, 2, 3, 0, 0, 1, 4);
    $display("test immediate done");
  endtask

  // back to back with the strobe held, then the answer must hold
  task automatic t_b2b;
    @(negedge i_clk);
    i_req   = 1'b1;
    i_instr = I_SWAP;
    i_case  = CASE_BEST;
    @(negedge i_clk);
    i_instr = I_MOVE_USP;
    i_case  = CASE_WORST;
    chk32({31'h0, o_valid}, 32'h0000_0001);
    chk_t(o_timing, mk(1, 0, 0, 0));
    @(negedge i_clk);
    i_req = 1'b0;
    chk32({31'h0, o_valid}, 32'h0000_0001);
    chk_t(o_timing, mk(3, 0, 1, 0));
    exp_clk = exp_clk + 32'h0000_0004;
    exp_n   = exp_n + 32'h0000_0002;
    chk32(o_acc_clocks, exp_clk);
    chk32(o_acc_instrs, exp_n);
    @(negedge i_clk);
    chk32({31'h0, o_valid}, 32'h0000_0000);
    chk_t(o_timing, mk(3, 0, 1, 0));
    $display("test back_to_back done");
  endtask

  task automatic t_reset;
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst   = 1'b0;
    exp_clk = '0;
    exp_n   = '0;
    chk32({31'h0, o_valid}, 32'h0000_0000);
    chk_t(o_timing, '0);
    chk32(o_acc_clocks, ACC_RESET);
    chk32(o_acc_instrs, ACC_RESET);
    q(I_MULTI_REG_LOAD, CASE_BEST, 2, add(mk(16, 2, 0, 0), at.calc_imm));
    $display("test reset done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // about 125 queries of two cycles each, with wide margin
  initial begin
    #20000;
    err_total++;
    complete_run();
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    exp_clk   = '0;
    exp_n     = '0;
    i_rst     = 1'b1;
    i_req     = 1'b0;
    i_instr   = I_EXG;
    i_case    = CASE_BEST;
    i_nregs   = '0;
    at        = {mk(3, 1, 0, 0), mk(5, 0, 1, 0), mk(9, 0, 2, 0), mk(17, 2, 1, 0)};
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    chk32(o_acc_instrs, ACC_RESET);
    t_multi();
    t_special();
    t_arith();
    t_imm();
    t_b2b();
    t_reset();
    complete_run();
  end
endmodule // tb_instruction_cycle_timing_model
`default_nettype wire
